/* core/btc_master_end.sv */
/*
 * Initiating end: issues the transfer cycles, carries the bus timer,
 * acts as interrupt handler and drives the acknowledge chain.
 * Assumes bus ownership arrives as a grant level from outside.
 */
// Notes on behaviour
// - address broadcast, then zero or more transfers
// - slave decodes address and modifier to respond
// - read: slave fetches, drives data, then acknowledges
// - write: slave stores data before acknowledging
// - master ends each acknowledged cycle
// - block moves 1 to 256 bytes
// - master holds bus through whole block
// - address sent once, slave advances it
// - read-modify-write location locked between halves
// - address-only cycle never acknowledged
// - bus timer ends overlong transfers
// - handler acknowledges only pending request, owning bus
// - acknowledge chain driven from first slot
module btc_master_end #(
	parameter int BUS_TIMEOUT_CYC = btc_pkg::BUS_TIMEOUT_CYC,
	parameter int TW = $clog2(BUS_TIMEOUT_CYC + 1)
) (
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	btc_transfer_bus_if.master bus,
	input wire logic bus_grant_i,
	input wire logic cmd_valid_i,
	output logic cmd_ready_o,
	input wire btc_pkg::btc_cyc_t cmd_cyc_i,
	input wire logic [btc_pkg::ADDR_W-1:0] cmd_addr_i,
	input wire logic [btc_pkg::AM_W-1:0] cmd_am_i,
	input wire logic [1:0] cmd_size_i,
	input wire logic cmd_wr_i,
	input wire logic [7:0] cmd_beats_i,
	input wire logic wd_valid_i,
	input wire logic [btc_pkg::DATA_W-1:0] wd_data_i,
	output logic wd_ready_o,
	output logic rd_valid_o,
	output logic vec_valid_o,
	output logic [btc_pkg::DATA_W-1:0] rd_data_o,
	output logic done_o,
	output logic timeout_o,
	output logic err_o,
	output logic busy_o
);
	import btc_pkg::*;

	typedef enum logic [2:0] {
		M_IDLE = 3'h0,
		M_SETUP = 3'h1,
		M_WAITWD = 3'h2,
		M_STROBE = 3'h3,
		M_RELEASE = 3'h4,
		M_END = 3'h5
	} btc_mstate_t;

	localparam logic [TW-1:0] T_LAST = TW'(BUS_TIMEOUT_CYC - 1);

	btc_mstate_t state;
	logic as_r;
	logic ds_r;
	logic [ADDR_W-1:0] addr_r;
	logic [AM_W-1:0] am_r;
	btc_cyc_t cyc_r;
	logic [1:0] size_r;
	logic wr_r;
	logic rmw_w;
	logic [7:0] left;
	logic [2:0] cnt;
	logic [TW-1:0] timer;
	logic [DATA_W-1:0] wdata_r;
	logic [DATA_W-1:0] rd_data;
	logic rd_valid;
	logic vec_valid;
	logic done;
	logic timeout;
	logic err;

	// ********************************
	// request decode
	// ********************************
	// interrupt acknowledge takes precedence over user commands
	wire start_iack = state == M_IDLE && bus_grant_i && bus.irq;
	wire cmd_take = cmd_valid_i && cmd_ready_o;
	wire [11:0] blk_bytes = (12'(cmd_beats_i) + 12'h1) *
		(12'(cmd_size_i) + 12'h1);
	wire blk_bad = cmd_cyc_i == CYC_BLOCK &&
		(cmd_size_i == SIZE_3BYTE || blk_bytes > MAX_BLOCK_BYTES);
	// user may not fake an acknowledge cycle
	wire cmd_bad = blk_bad || cmd_cyc_i == CYC_IACK;
	wire need_w = cyc_r == CYC_RMW ? rmw_w :
		(cyc_r == CYC_IACK ? 1'b0 : wr_r);
	wire wd_go = state == M_WAITWD && (!need_w || wd_valid_i);
	wire t_out = timer == T_LAST;

	assign cmd_ready_o = state == M_IDLE && bus_grant_i && !bus.irq;
	assign wd_ready_o = wd_go && need_w;
	assign busy_o = state != M_IDLE;

	// ********************************
	// bus drive
	// ********************************
	assign bus.addr_strobe = as_r;
	assign bus.addr = addr_r;
	assign bus.am = am_r;
	assign bus.cyc = cyc_r;
	assign bus.size = size_r;
	assign bus.write = need_w;
	assign bus.data_strobe = ds_r;
	assign bus.wdata = wdata_r;
	// chain starts here, ahead of every slot
	assign bus.iack_chain = as_r && ds_r && cyc_r == CYC_IACK;

	assign rd_valid_o = rd_valid;
	assign vec_valid_o = vec_valid;
	assign rd_data_o = rd_data;
	assign done_o = done;
	assign timeout_o = timeout;
	assign err_o = err;

	// ********************************
	// bus timer
	// ********************************
	// one count per transfer, restarted at every data strobe
	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i || wd_go)
			timer <= '0;
		else if ((state == M_STROBE || state == M_RELEASE) && !t_out)
			timer <= timer + TW'(1);
	end

	// ********************************
	// cycle sequencer
	// ********************************
	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i)
		begin
			state <= M_IDLE;
			as_r <= 1'b0;
			ds_r <= 1'b0;
			addr_r <= '0;
			am_r <= '0;
			cyc_r <= CYC_SINGLE;
			size_r <= 2'h0;
			wr_r <= 1'b0;
			rmw_w <= 1'b0;
			left <= 8'h00;
			cnt <= 3'h0;
			wdata_r <= '0;
			rd_data <= '0;
			rd_valid <= 1'b0;
			vec_valid <= 1'b0;
			done <= 1'b0;
			timeout <= 1'b0;
			err <= 1'b0;
		end
		else
		begin
			rd_valid <= 1'b0;
			vec_valid <= 1'b0;
			done <= 1'b0;
			timeout <= 1'b0;
			err <= 1'b0;
			unique case (state)
				M_IDLE:
				begin
					cnt <= 3'h0;
					rmw_w <= 1'b0;
					if (start_iack)
					begin
						// only with a request seen and the bus owned
						cyc_r <= CYC_IACK;
						addr_r <= '0;
						am_r <= IACK_AM;
						size_r <= 2'h3;
						wr_r <= 1'b0;
						left <= 8'h00;
						as_r <= 1'b1;
						state <= M_SETUP;
					end
					else if (cmd_take && cmd_bad)
						err <= 1'b1;
					else if (cmd_take)
					begin
						cyc_r <= cmd_cyc_i;
						addr_r <= cmd_addr_i;
						am_r <= cmd_am_i;
						size_r <= cmd_size_i;
						wr_r <= cmd_wr_i;
						left <= cmd_cyc_i == CYC_BLOCK ? cmd_beats_i : 8'h00;
						as_r <= 1'b1;
						state <= M_SETUP;
					end
				end
				M_SETUP:
					// hold the address before any data strobe
					if (cnt == SETUP_CYC - 3'h1)
						state <= cyc_r == CYC_AONLY ? M_END : M_WAITWD;
					else
						cnt <= cnt + 3'h1;
				M_WAITWD:
					if (wd_go)
					begin
						if (need_w)
							wdata_r <= wd_data_i;
						ds_r <= 1'b1;
						state <= M_STROBE;
					end
				M_STROBE:
					if (bus.dtack)
					begin
						if (!need_w)
							rd_data <= bus.rdata;
						rd_valid <= !need_w && cyc_r != CYC_IACK;
						vec_valid <= cyc_r == CYC_IACK;
						ds_r <= 1'b0;
						state <= M_RELEASE;
					end
					else if (t_out)
					begin
						ds_r <= 1'b0;
						timeout <= 1'b1;
						state <= M_END;
					end
				M_RELEASE:
					if (!bus.dtack)
					begin
						// address strobe stays up: no other master
						if (cyc_r == CYC_RMW && !rmw_w)
						begin
							rmw_w <= 1'b1;
							state <= M_WAITWD;
						end
						else if (left != 8'h00)
						begin
							left <= left - 8'h01;
							state <= M_WAITWD;
						end
						else
							state <= M_END;
					end
					else if (t_out)
					begin
						timeout <= 1'b1;
						state <= M_END;
					end
				M_END:
				begin
					as_r <= 1'b0;
					done <= 1'b1;
					state <= M_IDLE;
				end
				default:
					state <= M_IDLE;
			endcase
		end
	end
endmodule

/* core/btc_pkg.sv */
/*
 * Shared constants and types for the backplane transfer cycle ends.
 * Assumes one 125 MHz clock and a synchronous active-high reset
 * common to both ends.
 */
package btc_pkg;
	// ********************************
	// widths and timing
	// ********************************
	localparam int ADDR_W = 32;
	localparam int DATA_W = 32;
	localparam int AM_W = 6;
	localparam int CLK_NS = 8;
	localparam int ADDR_SETUP_NS = 24;
	// least time: round up
	localparam logic [2:0] SETUP_CYC =
		3'((ADDR_SETUP_NS + CLK_NS - 1) / CLK_NS);
	localparam int BUS_TIMEOUT_NS = 64000;
	// longest time: round down
	localparam int BUS_TIMEOUT_CYC = BUS_TIMEOUT_NS / CLK_NS;
	localparam logic [11:0] MAX_BLOCK_BYTES = 12'h100;
	localparam logic [1:0] SIZE_3BYTE = 2'h2;
	localparam logic [AM_W-1:0] IACK_AM = 6'h00;
	localparam logic [AM_W-1:0] DEF_SLAVE_AM = 6'h0D;

	// ********************************
	// cycle types sent with the address
	// ********************************
	typedef enum logic [2:0] {
		CYC_SINGLE = 3'h0,
		CYC_BLOCK = 3'h1,
		CYC_RMW = 3'h2,
		CYC_AONLY = 3'h3,
		CYC_IACK = 3'h4
	} btc_cyc_t;
endpackage

/* core/btc_slave_end.sv */
/*
 * Responding end: byte storage, address decode, block address advance,
 * locked read-modify-write and an interrupter on the acknowledge chain.
 * Assumes the initiating end keeps the strobe order of the transfer bus.
 */
module btc_slave_end #(
	parameter logic [31:0] BASE_ADDR = 32'h0000_0000,
	parameter logic [5:0] AM_CODE = btc_pkg::DEF_SLAVE_AM,
	parameter int STORE_BYTES = 256,
	parameter int ABITS = $clog2(STORE_BYTES)
) (
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	btc_transfer_bus_if.slave bus,
	input wire logic loc_req_i,
	input wire logic loc_we_i,
	input wire logic [ABITS-1:0] loc_addr_i,
	input wire logic [7:0] loc_wdata_i,
	output logic loc_ready_o,
	output logic [7:0] loc_rdata_o,
	input wire logic irq_req_i,
	input wire logic [btc_pkg::DATA_W-1:0] vector_i,
	output logic irq_pending_o
);
	import btc_pkg::*;

	typedef enum logic [1:0] {
		S_IDLE = 2'h0,
		S_ADDR = 2'h1,
		S_XFER = 2'h2,
		S_ACK = 2'h3
	} btc_sstate_t;

	btc_sstate_t state;
	logic [ADDR_W-1:0] cur_addr;
	btc_cyc_t cyc_q;
	logic [1:0] size_q;
	logic sel;
	logic pend;
	logic [DATA_W-1:0] vec;
	logic [DATA_W-1:0] rdata;
	logic [7:0] loc_rdata;
	logic [7:0] mem [STORE_BYTES];

	// ********************************
	// decode
	// ********************************
	wire hit = bus.am == AM_CODE && bus.addr >= BASE_ADDR &&
		bus.addr < BASE_ADDR + 32'(STORE_BYTES);
	wire is_iack = cyc_q == CYC_IACK;
	wire go = bus.data_strobe &&
		(is_iack ? (bus.iack_chain && pend) : sel);
	wire take = state == S_ADDR && go;
	wire bus_wr = take && bus.write && !is_iack;
	wire [ABITS-1:0] off = ABITS'(cur_addr - BASE_ADDR);
	wire rmw_lock = state != S_IDLE && cyc_q == CYC_RMW && sel;
	wire loc_take = loc_req_i && loc_ready_o;
	wire [31:0] step = 32'(size_q) + 32'h1;

	// bus access wins; a locked cycle keeps the local side off
	assign loc_ready_o = !rmw_lock && !take;
	assign loc_rdata_o = loc_rdata;
	assign bus.dtack = state == S_ACK;
	assign bus.rdata = rdata;
	assign bus.irq = pend;
	assign irq_pending_o = pend;
	// not pending: pass the chain on to later slots
	assign bus.iack_chain_out = bus.iack_chain && !pend;

	// ********************************
	// byte lanes and storage
	// ********************************
	logic [ABITS-1:0] lane_idx [4];
	logic [3:0] lane_on;
	logic [DATA_W-1:0] rd_word;

	for (genvar k = 0; k < 4; k++)
	begin : g_lane
		assign lane_idx[k] = off + ABITS'(k);
		assign lane_on[k] = 2'(k) <= size_q;
		assign rd_word[8*k +: 8] = lane_on[k] ? mem[lane_idx[k]] : 8'h00;
	end

	for (genvar j = 0; j < STORE_BYTES; j++)
	begin : g_byte
		logic [3:0] lane_hit;
		for (genvar k = 0; k < 4; k++)
		begin : g_hit
			assign lane_hit[k] = bus_wr && lane_on[k] &&
				lane_idx[k] == ABITS'(j);
		end
		always_ff @(posedge mclk_i)
		begin
			if (sys_rst_i)
				mem[j] <= 8'h00;
			else if (lane_hit[0])
				mem[j] <= bus.wdata[7:0];
			else if (lane_hit[1])
				mem[j] <= bus.wdata[15:8];
			else if (lane_hit[2])
				mem[j] <= bus.wdata[23:16];
			else if (lane_hit[3])
				mem[j] <= bus.wdata[31:24];
			else if (loc_take && loc_we_i && loc_addr_i == ABITS'(j))
				mem[j] <= loc_wdata_i;
		end
	end

	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i)
			loc_rdata <= 8'h00;
		else if (loc_take && !loc_we_i)
			loc_rdata <= mem[loc_addr_i];
	end

	// ********************************
	// interrupter
	// ********************************
	// a new request in the acknowledge cycle stays pending
	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i)
			pend <= 1'b0;
		else if (irq_req_i)
			pend <= 1'b1;
		else if (take && is_iack)
			pend <= 1'b0;
	end

	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i)
			vec <= '0;
		else if (irq_req_i && !pend)
			vec <= vector_i;
	end

	// ********************************
	// cycle sequencer
	// ********************************
	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i)
		begin
			state <= S_IDLE;
			cur_addr <= '0;
			cyc_q <= CYC_SINGLE;
			size_q <= 2'h0;
			sel <= 1'b0;
			rdata <= '0;
		end
		else if (!bus.addr_strobe)
			state <= S_IDLE;
		else
		begin
			unique case (state)
				S_IDLE:
				begin
					// address and modifier taken once per cycle
					cur_addr <= bus.addr;
					cyc_q <= bus.cyc;
					size_q <= bus.size;
					sel <= hit;
					state <= S_ADDR;
				end
				S_ADDR:
					if (go)
					begin
						// fetch or store before acknowledging
						if (is_iack)
							rdata <= vec;
						else if (!bus.write)
							rdata <= rd_word;
						state <= S_XFER;
					end
				S_XFER:
					state <= S_ACK;
				S_ACK:
					if (!bus.data_strobe)
					begin
						if (cyc_q == CYC_BLOCK)
							cur_addr <= cur_addr + step;
						size_q <= bus.size;
						state <= S_ADDR;
					end
			endcase
		end
	end
endmodule

/* core/btc_transfer_bus_if.sv */
/*
 * The transfer bus between the initiating end and the responding end.
 * Assumes both ends sit on the same clock; the bench joins them.
 */
interface btc_transfer_bus_if;
	import btc_pkg::*;
	logic addr_strobe;
	logic [ADDR_W-1:0] addr;
	logic [AM_W-1:0] am;
	btc_cyc_t cyc;
	logic [1:0] size;
	logic write;
	logic data_strobe;
	logic [DATA_W-1:0] wdata;
	logic iack_chain;
	logic dtack;
	logic [DATA_W-1:0] rdata;
	logic irq;
	logic iack_chain_out;

	modport master (
		output addr_strobe, addr, am, cyc, size, write, data_strobe,
		output wdata, iack_chain,
		input dtack, rdata, irq, iack_chain_out
	);
	modport slave (
		input addr_strobe, addr, am, cyc, size, write, data_strobe,
		input wdata, iack_chain,
		output dtack, rdata, irq, iack_chain_out
	);
endinterface

/* verification/btc_bus_checker.sv */
/*
 * Checker: timing relations on the transfer bus between both ends.
 * Assumes one clock, a synchronous reset, and bus signals wired in.
 */
module btc_bus_checker #(
	parameter int BUS_TIMEOUT_CYC = 20
) (
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	input wire logic addr_strobe,
	input wire logic [btc_pkg::ADDR_W-1:0] addr,
	input wire logic [btc_pkg::AM_W-1:0] am,
	input wire btc_pkg::btc_cyc_t cyc,
	input wire logic data_strobe,
	input wire logic iack_chain,
	input wire logic dtack,
	input wire logic irq,
	input wire logic iack_chain_out
);
	timeunit 1ns;
	timeprecision 1ps;
	import btc_pkg::*;
	// slack for the end handshake beyond the timer itself
	localparam int DS_MAX = BUS_TIMEOUT_CYC + 4;
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (sys_rst_i);

	// ********
	// sequences
	// ********
	sequence s_setup;
		!data_strobe [*3];
	endsequence
	sequence s_end;
		!data_strobe ##1 !dtack;
	endsequence

	// ********
	// checks
	// ********
	chk_strobe_in_cycle:
		assert property (data_strobe |-> addr_strobe)
		else $error("data strobe outside a cycle");
	chk_addr_setup:
		assert property ($rose(addr_strobe) |-> s_setup)
		else $error("data strobe before address setup");
	chk_addr_held:
		assert property (addr_strobe && $past(addr_strobe) |->
			$stable(addr) && $stable(am) && $stable(cyc))
		else $error("address changed within a cycle");
	chk_ack_delay:
		assert property ($rose(dtack) |->
			$past(data_strobe, 2) && data_strobe)
		else $error("acknowledge not two cycles after take");
	chk_master_ends:
		assert property ($rose(dtack) |=> s_end)
		else $error("acknowledged beat not ended");
	chk_aonly_silent:
		assert property (addr_strobe && cyc == CYC_AONLY |->
			!dtack && !data_strobe)
		else $error("address-only cycle saw a beat");
	chk_timer_bound:
		assert property ($rose(data_strobe) |-> ##[1:DS_MAX] !data_strobe)
		else $error("beat outlived the bus timer");
	chk_iack_pending:
		assert property ($rose(addr_strobe) && cyc == CYC_IACK |->
			irq && am == IACK_AM)
		else $error("acknowledge cycle without request");
	chk_chain_pass:
		assert property (iack_chain_out == (iack_chain && !irq))
		else $error("chain passed by pending interrupter");
endmodule

/* verification/tb_top.sv */
/*
 * Bench: both ends joined by the bus, driven from the user ports.
 * Assumes default slave base 0, 256 bytes, modifier DEF_SLAVE_AM.
 */
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import btc_pkg::*;
	localparam int TO_CYC = 20;
	// vector value is arbitrary
	localparam logic [31:0] VEC = 32'hA5C3_0F17;
	logic mclk_i = 1'b0, sys_rst_i = 1'b1, bus_grant_i = 1'b1;
	logic cmd_valid_i = 1'b0, cmd_wr_i = 1'b0, wd_valid_i = 1'b0;
	logic loc_req_i = 1'b0, loc_we_i = 1'b0, irq_req_i = 1'b0;
	btc_cyc_t cmd_cyc_i = CYC_SINGLE;
	logic [31:0] cmd_addr_i = 32'h0, wd_data_i = 32'h0, vector_i = 32'h0;
	logic [5:0] cmd_am_i = 6'h00;
	logic [1:0] cmd_size_i = 2'h0;
	logic [7:0] cmd_beats_i = 8'h00, loc_addr_i = 8'h00;
	logic [7:0] loc_wdata_i = 8'h00, loc_rdata_o, q;
	logic cmd_ready_o, wd_ready_o, rd_valid_o, vec_valid_o, done_o;
	logic timeout_o, err_o, busy_o, loc_ready_o, irq_pending_o;
	logic e_done, e_to, e_err, lock_bad = 1'b0;
	logic [31:0] rd_data_o, vec_seen = 32'h0;
	logic [31:0] wq[$], rq[$];
	int n_errors = 0;
	int samples_checked = 0;

	always #4 mclk_i = ~mclk_i;

	btc_transfer_bus_if bus_if();
	btc_master_end #(.BUS_TIMEOUT_CYC(TO_CYC)) btc_master_end_inst (
		.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .bus(bus_if.master),
		.bus_grant_i(bus_grant_i), .cmd_valid_i(cmd_valid_i),
		.cmd_ready_o(cmd_ready_o), .cmd_cyc_i(cmd_cyc_i),
		.cmd_addr_i(cmd_addr_i), .cmd_am_i(cmd_am_i),
		.cmd_size_i(cmd_size_i), .cmd_wr_i(cmd_wr_i),
		.cmd_beats_i(cmd_beats_i), .wd_valid_i(wd_valid_i),
		.wd_data_i(wd_data_i), .wd_ready_o(wd_ready_o),
		.rd_valid_o(rd_valid_o), .vec_valid_o(vec_valid_o),
		.rd_data_o(rd_data_o), .done_o(done_o), .timeout_o(timeout_o),
		.err_o(err_o), .busy_o(busy_o));
	btc_slave_end btc_slave_end_inst (
		.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .bus(bus_if.slave),
		.loc_req_i(loc_req_i), .loc_we_i(loc_we_i),
		.loc_addr_i(loc_addr_i), .loc_wdata_i(loc_wdata_i),
		.loc_ready_o(loc_ready_o), .loc_rdata_o(loc_rdata_o),
		.irq_req_i(irq_req_i), .vector_i(vector_i),
		.irq_pending_o(irq_pending_o));
	btc_bus_checker #(.BUS_TIMEOUT_CYC(TO_CYC)) btc_bus_checker_inst (
		.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
		.addr_strobe(bus_if.addr_strobe), .addr(bus_if.addr),
		.am(bus_if.am), .cyc(bus_if.cyc), .data_strobe(bus_if.data_strobe),
		.iack_chain(bus_if.iack_chain), .dtack(bus_if.dtack),
		.irq(bus_if.irq), .iack_chain_out(bus_if.iack_chain_out));

	// ********
	// tasks
	// ********
	task automatic chk(input string nm, input logic [31:0] seen, exp);
		samples_checked++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic end_sim();
		$display("checks %0d errors %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// lock window runs from read data to the write data handoff
	task automatic watch(input logic rmw);
		int i;
		logic lk;
		lk = 1'b0;
		for (i = 0; i < 1000; i++)
		begin
			@(posedge mclk_i);
			if (lk && loc_ready_o !== 1'b0)
				lock_bad = 1'b1;
			if (wd_ready_o === 1'b1 && wd_valid_i === 1'b1)
			begin
				void'(wq.pop_front());
				lk = 1'b0;
				wd_valid_i <= (wq.size() > 0);
				if (wq.size() > 0)
					wd_data_i <= wq[0];
			end
			if (rd_valid_o === 1'b1)
			begin
				rq.push_back(rd_data_o);
				lk = rmw;
			end
			if (vec_valid_o === 1'b1)
				vec_seen = rd_data_o;
			e_done = done_o;
			e_to = timeout_o;
			e_err = err_o;
			if (e_done === 1'b1 || e_to === 1'b1 || e_err === 1'b1)
				return;
		end
		chk("cycle_end_wait", 32'h0, 32'h1);
		end_sim();
	endtask

	task automatic cmd(input btc_cyc_t c, input logic [31:0] a,
		input logic [5:0] m, input logic [1:0] s, input logic w,
		input logic [7:0] b);
		int i;
		rq.delete();
		cmd_valid_i <= 1'b1;
		cmd_cyc_i <= c;
		cmd_addr_i <= a;
		cmd_am_i <= m;
		cmd_size_i <= s;
		cmd_wr_i <= w;
		cmd_beats_i <= b;
		wd_valid_i <= (wq.size() > 0);
		if (wq.size() > 0)
			wd_data_i <= wq[0];
		// request stands until ready is seen at an edge
		for (i = 0; i < 50; i++)
		begin
			@(posedge mclk_i);
			if (cmd_ready_o === 1'b1)
				break;
		end
		cmd_valid_i <= 1'b0;
		if (i == 50)
		begin
			chk("cmd_accept_wait", 32'h0, 32'h1);
			end_sim();
		end
		watch(c == CYC_RMW);
	endtask

	task automatic loc(input logic w, input logic [7:0] a, d);
		int i;
		loc_req_i <= 1'b1;
		loc_we_i <= w;
		loc_addr_i <= a;
		loc_wdata_i <= d;
		for (i = 0; i < 50; i++)
		begin
			@(posedge mclk_i);
			if (loc_ready_o === 1'b1)
				break;
		end
		loc_req_i <= 1'b0;
		@(posedge mclk_i);
		q = loc_rdata_o;
		if (i == 50)
		begin
			chk("loc_accept_wait", 32'h0, 32'h1);
			end_sim();
		end
	endtask

	// ********
	// sequence of tests
	// ********
	initial
	begin
		int i;
		repeat (8) @(posedge mclk_i);
		sys_rst_i <= 1'b0;
		@(posedge mclk_i);
		wq = '{32'h4433_2211};
		cmd(CYC_SINGLE, 32'h10, DEF_SLAVE_AM, 2'h3, 1'b1, 8'h00);
		chk("wr_done", e_done, 32'h1);
		for (i = 0; i < 4; i++)
		begin
			loc(1'b0, 8'(8'h10 + i), 8'h00);
			chk("wr_byte", q, 32'(8'h11 * (i + 1)));
		end
		loc(1'b1, 8'h30, 8'h5A);
		cmd(CYC_SINGLE, 32'h30, DEF_SLAVE_AM, 2'h0, 1'b0, 8'h00);
		chk("rd_byte", rq[0][7:0], 32'h5A);
		cmd(CYC_SINGLE, 32'h10, DEF_SLAVE_AM, 2'h3, 1'b0, 8'h00);
		chk("rd_word", rq[0], 32'h4433_2211);
		for (i = 0; i < 4; i++)
			wq.push_back({16'h0000, 16'hB0A0 + 16'(i)});
		cmd(CYC_BLOCK, 32'h20, DEF_SLAVE_AM, 2'h1, 1'b1, 8'h03);
		loc(1'b0, 8'h26, 8'h00);
		chk("blk_wr_byte", q, 32'hA3);
		cmd(CYC_BLOCK, 32'h20, DEF_SLAVE_AM, 2'h1, 1'b0, 8'h03);
		chk("blk_rd_count", rq.size(), 32'h4);
		for (i = 0; i < 4; i++)
			chk("blk_rd", rq[i][15:0], 32'hB0A0 + i);
		cmd(CYC_BLOCK, 32'h0, DEF_SLAVE_AM, 2'h3, 1'b0, 8'h3F);
		chk("blk_256_count", rq.size(), 32'h40);
		chk("blk_256_word", rq[4], 32'h4433_2211);
		cmd(CYC_BLOCK, 32'h0, DEF_SLAVE_AM, 2'h2, 1'b0, 8'h00);
		chk("bad_size", e_err, 32'h1);
		cmd(CYC_BLOCK, 32'h0, DEF_SLAVE_AM, 2'h3, 1'b0, 8'h40);
		chk("bad_length", e_err, 32'h1);
		cmd(CYC_IACK, 32'h0, IACK_AM, 2'h3, 1'b0, 8'h00);
		chk("bad_iack", e_err, 32'h1);
		wq = '{32'h8877_6655};
		cmd(CYC_RMW, 32'h10, DEF_SLAVE_AM, 2'h3, 1'b1, 8'h00);
		chk("rmw_read", rq[0], 32'h4433_2211);
		chk("rmw_lock", lock_bad, 32'h0);
		loc(1'b0, 8'h10, 8'h00);
		chk("rmw_write", q, 32'h55);
		cmd(CYC_AONLY, 32'h10, DEF_SLAVE_AM, 2'h0, 1'b0, 8'h00);
		chk("aonly_done", e_done, 32'h1);
		chk("aonly_no_data", rq.size(), 32'h0);
		cmd(CYC_SINGLE, 32'h1000, DEF_SLAVE_AM, 2'h3, 1'b0, 8'h00);
		chk("no_slave", e_to, 32'h1);
		cmd(CYC_SINGLE, 32'h10, 6'h09, 2'h3, 1'b0, 8'h00);
		chk("wrong_mod", e_to, 32'h1);
		// no grant: request must wait, pending, for bus control
		bus_grant_i <= 1'b0;
		irq_req_i <= 1'b1;
		vector_i <= VEC;
		@(posedge mclk_i);
		irq_req_i <= 1'b0;
		repeat (6) @(posedge mclk_i);
		chk("held_ready", cmd_ready_o, 32'h0);
		chk("held_pending", irq_pending_o, 32'h1);
		chk("held_idle", busy_o, 32'h0);
		bus_grant_i <= 1'b1;
		watch(1'b0);
		chk("vector", vec_seen, VEC);
		@(posedge mclk_i);
		chk("pending_clear", irq_pending_o, 32'h0);
		end_sim();
	end
endmodule
